/* pkg/spm_defines.svh */
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH
// Function
// - The unit is always in exactly one of Off, Asleep or Awake, which sets its power draw and logging ability.
// - With no power the unit collects nothing, and once powered it is either Awake or Asleep.
// - While Asleep the unit stays in low power until a host command or an approaching logging slot.
// - The unit drops the radio and sleeps after 5 minutes without wireless traffic and 30 seconds without cabled traffic.
// - The unit wakes by itself 15 seconds before each scheduled logging slot.
// - The radio LED is dark when the radio is off, steady when on without a link, and blinks at 2 Hz when linked.
// - The state LED is dark when Off or Asleep without logging, and blinks once per ten seconds when Asleep with logging.
// - The state LED blinks at 1 Hz when Awake without faults and is lit steadily when Awake with faults.
// - A magnet at the activation area turns the radio on.
// - A battery power cycle, cabled-port traffic or a sensor insertion also wakes the unit.
// - A battery power cycle or a cabled host command also turns the radio on.
// - Awake has three modes: inactive, real-time at a host-set interval defaulting to 2 Hz, and sample-and-hold.
// - Sensor readings are reported in ascending port order, port 1 first.

// time base
`define SPM_CLK_HZ          25000000
`define SPM_TICK_MS         10
`define SPM_TICK_CYC        ((`SPM_CLK_HZ / 1000) * `SPM_TICK_MS)
// timeouts and lead, in seconds, converted to ticks
`define SPM_RADIO_TO_S      300
`define SPM_CABLE_TO_S      30
`define SPM_WAKE_LEAD_S     15
`define SPM_TICKS_PER_S     (1000 / `SPM_TICK_MS)
`define SPM_RADIO_TO_TK     (`SPM_RADIO_TO_S * `SPM_TICKS_PER_S)
`define SPM_CABLE_TO_TK     (`SPM_CABLE_TO_S * `SPM_TICKS_PER_S)
`define SPM_WAKE_LEAD_TK    (`SPM_WAKE_LEAD_S * `SPM_TICKS_PER_S)
// blink half periods in ticks: 2 Hz, 1 Hz; 0.1 Hz as full period and on time (short flash)
`define SPM_RADIO_HALF_TK   25
`define SPM_AWAKE_HALF_TK   50
`define SPM_SLEEP_PER_TK    1000
`define SPM_SLEEP_ON_TK     10
// default real-time interval in ticks (2 Hz)
`define SPM_RT_DEF_TK       16'h0032
// register byte offsets
`define SPM_REG_CTRL        4'h0
`define SPM_REG_STATUS      4'h4
`define SPM_REG_SCHED       4'h8
`define SPM_REG_RTIV        4'hC
// control bits
`define SPM_CTRL_LOG_EN     0
`define SPM_CTRL_RADIO_CMD  1
`define SPM_CTRL_SLEEP_CMD  2
`define SPM_CTRL_WAKE_CMD   3
`define SPM_CTRL_MODE_LO    4
`endif

/* pkg/spm_pkg.sv */
package spm_pkg;
	typedef enum logic [2:0] {
		SPM_OFF    = 3'b001,
		SPM_ASLEEP = 3'b010,
		SPM_AWAKE  = 3'b100
	} spm_state_e;
	typedef enum logic [1:0] {
		SPM_MODE_INACTIVE = 2'b00,
		SPM_MODE_REALTIME = 2'b01,
		SPM_MODE_HOLD     = 2'b10
	} spm_mode_e;
endpackage : spm_pkg

/* rtl/spm_blinker.sv */
`include "spm_defines.svh"
// tick-driven blink pattern: lit for on_tk ticks of every per_tk ticks
module spm_blinker (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        tick,
	input  wire logic [10:0] per_tk,
	input  wire logic [10:0] on_tk,
	output logic             blink
);
	logic [10:0] cnt_q;
	wire         wrap = (cnt_q >= per_tk - 11'h001);
	// restart phase on wrap so period changes settle within one period
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			cnt_q <= 11'h000;
		else if (tick)
			cnt_q <= wrap ? 11'h000 : cnt_q + 11'h001;
	end
	assign blink = (cnt_q < on_tk);
endmodule : spm_blinker

/* rtl/spm_power_led.sv */
`include "spm_defines.svh"
module spm_power_led (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        pwr_present,
	input  wire logic        magnet_det,
	input  wire logic        cable_act,
	input  wire logic        radio_act,
	input  wire logic        radio_linked,
	input  wire logic        sensor_ins,
	input  wire logic        fault,
	input  wire logic        sample_req,
	output logic             radio_en,
	output logic             core_awake,
	output logic             log_strobe,
	output logic [2:0]       rpt_port,
	output logic             radio_led,
	output logic             state_led
);
	////////////////////////////////////////////////////////////////////////////
	// registers and time base
	spm_pkg::spm_state_e state_q, state_d;
	logic [20:0] div_q;
	logic        tick;
	logic [15:0] radio_to_q, cable_to_q, sched_q, rt_q;
	logic [15:0] sched_iv_q, rtiv_q;
	logic        log_en_q, pwr_q, pwr_cycle, radio_q, log_q;
	logic [1:0]  mode_q;
	logic [2:0]  port_q;
	logic        ack_q;
	logic [31:0] rdat_q;
	logic        rb_radio, rb_awake;
	logic        ledr_q, leds_q;

	assign tick = (div_q == 21'(`SPM_TICK_CYC - 1));
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			div_q <= 21'h000000;
		else
			div_q <= tick ? 21'h000000 : div_q + 21'h000001;
	end

	////////////////////////////////////////////////////////////////////////////
	// wishbone slave: one wait state, ack drops after one cycle
	wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
	wire wr      = bus_req & wb_we_i & wb_sel_i[0];
	wire wr_ctrl = wr & (wb_adr_i == `SPM_REG_CTRL);
	wire wr_sch  = wr & (wb_adr_i == `SPM_REG_SCHED);
	wire wr_rtiv = wr & (wb_adr_i == `SPM_REG_RTIV);
	// a ctrl write counts as cabled host traffic
	wire host_cmd = wr_ctrl;
	wire [31:0] rd_mux =
		(wb_adr_i == `SPM_REG_CTRL)   ? {26'h0, mode_q, 3'b000, log_en_q} :
		(wb_adr_i == `SPM_REG_STATUS) ? {24'h0, port_q, fault, radio_linked,
		                                 state_q} :
		(wb_adr_i == `SPM_REG_SCHED)  ? {16'h0, sched_iv_q} :
		(wb_adr_i == `SPM_REG_RTIV)   ? {16'h0, rtiv_q} : 32'h00000000;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h00000000;
		end else begin
			ack_q  <= bus_req;
			rdat_q <= rd_mux;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	////////////////////////////////////////////////////////////////////////////
	// host configuration
	// mode and real-time interval, default 2 Hz
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			log_en_q   <= 1'b0;
			mode_q     <= 2'b00;
			sched_iv_q <= 16'h0000;
			rtiv_q     <= `SPM_RT_DEF_TK;
		end else begin
			if (wr_ctrl) begin
				log_en_q <= wb_dat_i[`SPM_CTRL_LOG_EN];
				mode_q   <= wb_dat_i[`SPM_CTRL_MODE_LO+:2];
			end
			if (wr_sch)
				sched_iv_q <= wb_dat_i[15:0];
			if (wr_rtiv)
				rtiv_q <= (wb_dat_i[15:0] == 16'h0000) ? 16'h0001 : wb_dat_i[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// wake events
	// power cycle seen as power returning
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			pwr_q <= 1'b0;
		else
			pwr_q <= pwr_present;
	end
	assign pwr_cycle = pwr_present & ~pwr_q;
	wire cable_evt = cable_act | host_cmd;
	wire sched_due  = log_en_q & (sched_iv_q != 16'h0000) &
	                  (sched_q <= 16'(`SPM_WAKE_LEAD_TK));
	// leave sleep on host command, schedule, power cycle, magnet, cable traffic or sensor
	wire wake_cmd   = host_cmd & wb_dat_i[`SPM_CTRL_WAKE_CMD];
	wire wake_evt   = pwr_cycle | magnet_det | cable_evt | sensor_ins | wake_cmd |
	                  sched_due;
	wire sleep_cmd  = host_cmd & wb_dat_i[`SPM_CTRL_SLEEP_CMD];
	// both links idle beyond their limits
	wire idle       = (radio_to_q == 16'h0000) & (cable_to_q == 16'h0000);

	////////////////////////////////////////////////////////////////////////////
	// one-hot state machine, off without power
	always_comb begin
		state_d = state_q;
		case (state_q)
			spm_pkg::SPM_OFF:
				if (pwr_present)
					state_d = spm_pkg::SPM_AWAKE;
			spm_pkg::SPM_ASLEEP:
				if (!pwr_present)
					state_d = spm_pkg::SPM_OFF;
				else if (wake_evt)
					state_d = spm_pkg::SPM_AWAKE;
			spm_pkg::SPM_AWAKE:
				if (!pwr_present)
					state_d = spm_pkg::SPM_OFF;
				// a wake event in the timeout cycle keeps the unit awake
				else if ((idle & ~sched_due & ~wake_evt) | sleep_cmd)
					state_d = spm_pkg::SPM_ASLEEP;
			default:
				state_d = spm_pkg::SPM_OFF;
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			state_q <= spm_pkg::SPM_OFF;
		else
			state_q <= state_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// inactivity timers restart on traffic
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			radio_to_q <= 16'h0000;
			cable_to_q <= 16'h0000;
		end else begin
			if (radio_act | magnet_det | pwr_cycle | (state_d != state_q &&
			    state_d == spm_pkg::SPM_AWAKE))
				radio_to_q <= 16'(`SPM_RADIO_TO_TK);
			else if (tick && radio_to_q != 16'h0000)
				radio_to_q <= radio_to_q - 16'h0001;
			if (cable_evt)
				cable_to_q <= 16'(`SPM_CABLE_TO_TK);
			else if (tick && cable_to_q != 16'h0000)
				cable_to_q <= cable_to_q - 16'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			sched_q <= 16'h0000;
		else if (wr_sch || sched_q == 16'h0000)
			sched_q <= wr_sch ? wb_dat_i[15:0] : sched_iv_q;
		else if (tick)
			sched_q <= sched_q - 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////////
	// radio enable: magnet, power cycle or host, off whenever the unit leaves Awake
	wire radio_cmd = host_cmd & wb_dat_i[`SPM_CTRL_RADIO_CMD];
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			radio_q <= 1'b0;
		else if (state_d != spm_pkg::SPM_AWAKE)
			radio_q <= 1'b0;
		else if (magnet_det | pwr_cycle | radio_cmd)
			radio_q <= 1'b1;
	end
	assign radio_en   = radio_q;
	// one-hot awake bit, straight from the state flop
	assign core_awake = state_q[2];

	////////////////////////////////////////////////////////////////////////////
	// real-time sampling and hold strobes, port order
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rt_q   <= 16'h0000;
			log_q  <= 1'b0;
			port_q <= 3'h1;
		end else begin
			log_q <= 1'b0;
			if (state_q != spm_pkg::SPM_AWAKE || mode_q == 2'b00)
				rt_q <= rtiv_q;
			else if (mode_q == 2'b01 && tick) begin
				rt_q <= (rt_q <= 16'h0001) ? rtiv_q : rt_q - 16'h0001;
				log_q <= (rt_q <= 16'h0001);
			end else if (mode_q == 2'b10)
				log_q <= sample_req;
			// readings go out port 1 upward, holding at the last port
			if (log_q)
				port_q <= 3'h1;
			else if (port_q != 3'h7)
				port_q <= port_q + 3'h1;
		end
	end
	assign log_strobe = log_q;
	assign rpt_port   = port_q;

	////////////////////////////////////////////////////////////////////////////
	// leds
	spm_blinker u_rb (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.tick     (tick),
		.per_tk   (11'(2 * `SPM_RADIO_HALF_TK)),
		.on_tk    (11'(`SPM_RADIO_HALF_TK)),
		.blink    (rb_radio)
	);
	wire         asleep = (state_q == spm_pkg::SPM_ASLEEP);
	wire [10:0]  sper   = asleep ? 11'(`SPM_SLEEP_PER_TK) : 11'(2 * `SPM_AWAKE_HALF_TK);
	wire [10:0]  son    = asleep ? 11'(`SPM_SLEEP_ON_TK) : 11'(`SPM_AWAKE_HALF_TK);
	spm_blinker u_sb (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.tick     (tick),
		.per_tk   (sper),
		.on_tk    (son),
		.blink    (rb_awake)
	);
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ledr_q <= 1'b0;
			leds_q <= 1'b0;
		end else begin
			ledr_q <= radio_q & (radio_linked ? rb_radio : 1'b1);
			case (state_q)
				spm_pkg::SPM_AWAKE:  leds_q <= fault | rb_awake;
				spm_pkg::SPM_ASLEEP: leds_q <= log_en_q & rb_awake;
				default:             leds_q <= 1'b0;
			endcase
		end
	end
	assign radio_led = ledr_q;
	assign state_led = leds_q;

	////////////////////////////////////////////////////////////////////////////
	// checks
	a_off_no_pwr: assert property (@(posedge core_clk) disable iff (!rst_b)
		!pwr_present |=> state_q != spm_pkg::SPM_AWAKE)
		else $error("awake without power");
	a_state_onehot: assert property (@(posedge core_clk) disable iff (!rst_b)
		$onehot(state_q)) else $error("state not one-hot");
	a_magnet_radio: assert property (@(posedge core_clk) disable iff (!rst_b)
		magnet_det && pwr_present |=> radio_q) else $error("magnet missed");
	a_led_radio_off: assert property (@(posedge core_clk) disable iff (!rst_b)
		!radio_q |=> !ledr_q) else $error("radio led lit while off");
	a_led_fault: assert property (@(posedge core_clk) disable iff (!rst_b)
		core_awake && fault |=> leds_q) else $error("fault led dark");
	a_led_sleep: assert property (@(posedge core_clk) disable iff (!rst_b)
		asleep && !log_en_q |=> !leds_q) else $error("sleep led lit");
	a_wake_sensor: assert property (@(posedge core_clk) disable iff (!rst_b)
		asleep && sensor_ins && pwr_present |=> core_awake) else $error("no wake");
	a_sleep_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
		core_awake && idle && !sched_due && !wake_evt && pwr_present |=> asleep)
		else $error("no sleep when idle");
endmodule : spm_power_led

/* test/spm_host_model.sv */
// host behind the radio and cable: link level and one-cycle traffic pulses
module spm_host_model (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic radio_en,
	input  wire logic link_up,
	input  wire logic send_radio,
	input  wire logic send_cable,
	output logic      radio_linked,
	output logic      radio_act,
	output logic      cable_act
);
	timeunit 1ns;
	timeprecision 100ps;
	////////////////////////////////////////////////////////////////////////////////
	// a host cannot hold a link or send radio traffic to a radio that is off
	// link needs radio
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			radio_linked <= 1'b0;
			radio_act    <= 1'b0;
			cable_act    <= 1'b0;
		end else begin
			radio_linked <= link_up & radio_en;
			radio_act    <= send_radio & radio_en;
			cable_act    <= send_cable;
		end
	end
endmodule : spm_host_model

/* test/sonde_power_state_led_manager_tb_top.sv */
`include "spm_defines.svh"
module sonde_power_state_led_manager_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        core_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0]  wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, seen;
	logic        pwr_present, magnet_det, cable_act, radio_act, radio_linked, sensor_ins;
	logic        fault, sample_req, radio_en, core_awake, log_strobe, radio_led, state_led;
	logic [2:0]  rpt_port;
	logic        link_up, send_radio, send_cable;
	logic [4:0]  ev;
	int          n_mismatch, checks;
	// event pulses share one vector so a single task raises any of them
	assign sensor_ins = ev[0];
	assign send_cable = ev[1];
	assign magnet_det = ev[2];
	assign sample_req = ev[3];
	assign send_radio = ev[4];
	spm_power_led i_spm_power_led (.core_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pwr_present, .magnet_det,
		.cable_act, .radio_act, .radio_linked, .sensor_ins, .fault, .sample_req, .radio_en,
		.core_awake, .log_strobe, .rpt_port, .radio_led, .state_led);
	spm_host_model i_spm_host_model (.core_clk, .rst_b, .radio_en, .link_up, .send_radio,
		.send_cable, .radio_linked, .radio_act, .cable_act);
	////////////////////////////////////////////////////////////////////////////////
	// 25 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic summarize();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string what, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, e, s);
		end
	endtask : chk
	task automatic chk1(input string what, input logic s, input logic e);
		chk(what, {31'h0, s}, {31'h0, e});
	endtask : chk1
	// one classic cycle; request held until ack is sampled, then released
	task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [3:0] sel,
			input logic [31:0] wd, output logic [31:0] q);
		int n;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= wd;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 16);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		if (n >= 16) begin
			n_mismatch++;
			summarize();
		end
	endtask : wb_xfer
	task automatic wr(input logic [3:0] adr, input logic [31:0] d);
		logic [31:0] q;
		wb_xfer(1'b1, adr, 4'hF, d, q);
	endtask : wr
	task automatic rdm(input logic [3:0] adr, input logic [31:0] mask, input logic [31:0] e);
		logic [31:0] q;
		wb_xfer(1'b0, adr, 4'hF, 32'h0, q);
		chk($sformatf("reg %h", adr), q & mask, e);
	endtask : rdm
	task automatic pulse(input int which);
		@(posedge core_clk);
		ev <= 5'h01 << which;
		@(posedge core_clk);
		ev <= 5'h00;
	endtask : pulse
	// bounded wait for the power state, a hang ends the run
	task automatic wait_awake(input logic e);
		int n;
		n = 0;
		while (core_awake !== e && n < 16) begin
			@(negedge core_clk);
			n++;
		end
		chk1("core_awake", core_awake, e);
		if (n >= 16) summarize();
		repeat (4) @(negedge core_clk);
	endtask : wait_awake
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst_b = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i, pwr_present, fault, link_up} = 6'h00;
		{wb_adr_i, wb_sel_i, wb_dat_i, ev} = '0;
		n_mismatch = 0;
		checks = 0;
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		@(negedge core_clk);
		chk("rpt_port", {29'h0, rpt_port}, 32'h1);
		chk1("radio_en", radio_en, 1'b0);
		chk1("state_led", state_led, 1'b0);
		// port index has stepped once to 2 by the edge that takes the read
		rdm(`SPM_REG_STATUS, 32'hFF, 32'h41);
		rdm(`SPM_REG_RTIV, 32'hFFFF, {16'h0, `SPM_RT_DEF_TK});
		rdm(`SPM_REG_SCHED, 32'hFFFF, 32'h0);
		rdm(4'h6, 32'hFFFFFFFF, 32'h0);
		// a write without byte lane 0 must be dropped
		wb_xfer(1'b1, `SPM_REG_RTIV, 4'h0, 32'h7, seen);
		rdm(`SPM_REG_RTIV, 32'hFFFF, {16'h0, `SPM_RT_DEF_TK});
		wr(`SPM_REG_RTIV, 32'h64);
		rdm(`SPM_REG_RTIV, 32'hFFFF, 32'h64);
		// power arriving counts as a power cycle
		@(posedge core_clk);
		pwr_present <= 1'b1;
		wait_awake(1'b1);
		chk1("radio_en", radio_en, 1'b1);
		chk1("radio_led", radio_led, 1'b1);
		rdm(`SPM_REG_STATUS, 32'h1F, 32'h04);
		fault <= 1'b1;
		repeat (6) @(negedge core_clk);
		chk1("state_led", state_led, 1'b1);
		rdm(`SPM_REG_STATUS, 32'h1F, 32'h14);
		chk1("state_led", state_led, 1'b1);
		fault <= 1'b0;
		link_up <= 1'b1;
		pulse(4);
		repeat (4) @(negedge core_clk);
		rdm(`SPM_REG_STATUS, 32'h1F, 32'h0C);
		chk1("core_awake", core_awake, 1'b1);
		link_up <= 1'b0;
		// sleep, stay asleep, then wake by sensor, cable traffic and magnet
		for (int i = 0; i < 3; i++) begin
			wr(`SPM_REG_CTRL, 32'h4);
			wait_awake(1'b0);
			chk1("radio_en", radio_en, 1'b0);
			chk1("radio_led", radio_led, 1'b0);
			chk1("state_led", state_led, 1'b0);
			rdm(`SPM_REG_STATUS, 32'h07, 32'h02);
			repeat (200) @(negedge core_clk);
			chk1("core_awake", core_awake, 1'b0);
			pulse(i);
			wait_awake(1'b1);
			if (i == 2) chk1("radio_en", radio_en, 1'b1);
		end
		// logging on but no schedule: asleep until a schedule inside the lead is set
		wr(`SPM_REG_CTRL, 32'h5);
		wait_awake(1'b0);
		repeat (200) @(negedge core_clk);
		chk1("core_awake", core_awake, 1'b0);
		wr(`SPM_REG_SCHED, 32'h10);
		wait_awake(1'b1);
		wr(`SPM_REG_CTRL, 32'h4);
		wait_awake(1'b0);
		wr(`SPM_REG_CTRL, 32'h8);
		wait_awake(1'b1);
		// a plain wake leaves the radio off until the host asks for it
		chk1("radio_en", radio_en, 1'b0);
		wr(`SPM_REG_CTRL, 32'h2);
		chk1("radio_en", radio_en, 1'b1);
		// losing power forces off, its return is a power cycle
		@(posedge core_clk);
		pwr_present <= 1'b0;
		wait_awake(1'b0);
		rdm(`SPM_REG_STATUS, 32'h07, 32'h01);
		chk1("radio_en", radio_en, 1'b0);
		chk1("state_led", state_led, 1'b0);
		@(posedge core_clk);
		pwr_present <= 1'b1;
		wait_awake(1'b1);
		chk1("radio_en", radio_en, 1'b1);
		// hold mode: one strobe per request and none without
		wr(`SPM_REG_CTRL, 32'h20);
		rdm(`SPM_REG_CTRL, 32'h3F, 32'h20);
		pulse(3);
		seen = 32'h0;
		repeat (16) begin
			@(negedge core_clk);
			if (log_strobe === 1'b1) begin
				seen++;
				@(negedge core_clk);
				chk("rpt_port first", {29'h0, rpt_port}, 32'h1);
				@(negedge core_clk);
				chk("rpt_port second", {29'h0, rpt_port}, 32'h2);
			end
		end
		chk("hold strobes", seen, 32'h1);
		seen = 32'h0;
		repeat (200) begin
			@(negedge core_clk);
			if (log_strobe !== 1'b0) seen++;
		end
		chk("idle strobes", seen, 32'h0);
		// real-time mode ignores the hold request line
		wr(`SPM_REG_CTRL, 32'h10);
		pulse(3);
		seen = 32'h0;
		repeat (16) begin
			@(negedge core_clk);
			if (log_strobe !== 1'b0) seen++;
		end
		chk("realtime strobes", seen, 32'h0);
		summarize();
	end
endmodule : sonde_power_state_led_manager_tb_top
